// ==== lfc_fault_ctrl.v ====
// fault response configuration and fault flags that clear on read except while latched off
`timescale 1ns/100ps
`include "lfc_regs.vh"

module lfc_fault_ctrl #(
	parameter CHANNELS = 3
) (
	input wire core_clk_i,
	input wire reset_n_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	output reg [7:0] reg_rdata_o,
	input wire [CHANNELS-1:0] sink_above_2v_i,
	input wire [CHANNELS-1:0] sink_above_3v_i,
	input wire [CHANNELS-1:0] sink_above_5v_i,
	input wire [CHANNELS-1:0] string_open_i,
	input wire overvoltage_i,
	input wire undervoltage_i,
	input wire thermal_i,
	input wire overcurrent_i,
	input wire flash_timeout_i,
	input wire flash_enable_wr_i,
	input wire flash_enable_wdata_i,
	output reg flash_mode_enable_o,
	output reg [CHANNELS-1:0] string_off_o,
	output reg chip_latched_off_o,
	output wire [1:0] short_threshold_sel_o
);

	reg [7:0] cfg_q;
	reg [7:0] cfg_d;
	reg [5:0] flags_q;
	reg [5:0] flags_d;
	reg [5:0] flag_set;
	reg latch_d;
	reg [CHANNELS-1:0] string_off_d;
	reg flash_d;
	reg [7:0] rdata_d;
	reg [CHANNELS-1:0] short_det;
	reg short_evt;
	reg open_evt;
	reg any_evt;
	reg latch_req;
	reg [CHANNELS-1:0] drop_req;
	wire [1:0] th_sel;
	wire [1:0] smd;
	wire [1:0] omd;
	wire otp_dis;
	wire ocp_dis;
	wire wr_cfg;
	wire rd_cfg;
	wire rd_flags;
	wire rd_clear;

	// address match, shared by the write and read decode
	function addr_hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			addr_hit = (addr == target);
		end
	endfunction

	// mode field compare, used by the short and open mode decodes
	function mode_is;
		input [1:0] field;
		input [1:0] code;
		begin
			mode_is = (field == code);
		end
	endfunction

	// per-string sticky off
	function [CHANNELS-1:0] sticky;
		input [CHANNELS-1:0] held;
		input [CHANNELS-1:0] set;
		begin
			sticky = held | set;
		end
	endfunction

	// reserved threshold code detects nothing rather than guessing a level
	function [CHANNELS-1:0] pick_level;
		input [1:0] code;
		input [CHANNELS-1:0] lvl_2v;
		input [CHANNELS-1:0] lvl_3v;
		input [CHANNELS-1:0] lvl_5v;
		begin
			case (code)
			2'h0: begin
				pick_level = lvl_2v;
			end
			2'h1: begin
				pick_level = lvl_3v;
			end
			2'h2: begin
				pick_level = lvl_5v;
			end
			default: begin
				pick_level = {CHANNELS{1'b0}};
			end
			endcase
		end
	endfunction

	assign th_sel = cfg_q[`LFC_TH_HI:`LFC_TH_LO];
	assign smd = cfg_q[`LFC_SMD_HI:`LFC_SMD_LO];
	assign omd = cfg_q[`LFC_OMD_HI:`LFC_OMD_LO];
	assign otp_dis = cfg_q[`LFC_OTP_DIS];
	assign ocp_dis = cfg_q[`LFC_OCP_DIS];
	assign short_threshold_sel_o = th_sel;

	assign wr_cfg = reg_wr_i && addr_hit(reg_addr_i, `LFC_ADDR_CFG);
	assign rd_cfg = reg_rd_i && addr_hit(reg_addr_i, `LFC_ADDR_CFG);
	assign rd_flags = reg_rd_i && addr_hit(reg_addr_i, `LFC_ADDR_FLAGS);
	// flags not cleared by reads while latched off so the cause survives to reset
	assign rd_clear = rd_flags && !chip_latched_off_o;

	always @* begin
		short_det = pick_level(th_sel, sink_above_2v_i, sink_above_3v_i, sink_above_5v_i);
	end

	always @* begin
		short_evt = 1'b0;
		open_evt = |string_open_i;
		if (!mode_is(smd, `LFC_SMD_OFF)) begin
			short_evt = |short_det;
		end
	end

	// requests are ORed, so any cause wins
	always @* begin
		drop_req = {CHANNELS{1'b0}};
		latch_req = 1'b0;
		if (mode_is(smd, `LFC_SMD_STR)) begin
			drop_req = drop_req | short_det;
		end
		if (mode_is(smd, `LFC_SMD_LATCH)) begin
			if (short_evt) begin
				latch_req = 1'b1;
			end
		end
		if (mode_is(omd, `LFC_OMD_STR)) begin
			if (overvoltage_i) begin
				drop_req = drop_req | string_open_i;
			end
		end
		if (mode_is(omd, `LFC_OMD_LATCH)) begin
			if (overvoltage_i) begin
				latch_req = 1'b1;
			end
		end
		if (thermal_i) begin
			if (!otp_dis) begin
				latch_req = 1'b1;
			end
		end
		if (overcurrent_i) begin
			if (!ocp_dis) begin
				latch_req = 1'b1;
			end
		end
	end

	// any detected fault counts as a protection event for flash
	always @* begin
		any_evt = 1'b0;
		if (short_evt || open_evt) begin
			any_evt = 1'b1;
		end
		if (overvoltage_i || undervoltage_i) begin
			any_evt = 1'b1;
		end
		if (thermal_i || overcurrent_i) begin
			any_evt = 1'b1;
		end
	end

	always @* begin
		flag_set = 6'h00;
		flag_set[`LFC_F_UV] = undervoltage_i;
		flag_set[`LFC_F_OPEN] = open_evt;
		flag_set[`LFC_F_SHORT] = short_evt;
		flag_set[`LFC_F_OT] = thermal_i;
		flag_set[`LFC_F_OC] = overcurrent_i;
		flag_set[`LFC_F_OV] = overvoltage_i;
	end

	// clear first, then set, so a fault in the read cycle is not lost
	always @* begin
		flags_d = flags_q;
		if (rd_clear) begin
			flags_d = 6'h00;
		end
		flags_d = flags_d | flag_set;
	end

	always @* begin
		cfg_d = cfg_q;
		if (wr_cfg) begin
			cfg_d = reg_wdata_i;
		end
	end

	// fault clearing does not release the latch, only reset does
	always @* begin
		latch_d = chip_latched_off_o;
		if (latch_req) begin
			latch_d = 1'b1;
		end
	end

	// dropped strings stay off until reset
	always @* begin
		string_off_d = sticky(string_off_o, drop_req);
	end

	// timeout and protection win over a host enable in the same cycle
	always @* begin
		flash_d = flash_mode_enable_o;
		if (flash_timeout_i || any_evt) begin
			flash_d = 1'b0;
		end else if (flash_enable_wr_i) begin
			flash_d = flash_enable_wdata_i;
		end
	end

	// read data moves only on a read; unmapped reads give zero
	always @* begin
		rdata_d = reg_rdata_o;
		if (reg_rd_i) begin
			rdata_d = 8'h00;
			if (rd_cfg) begin
				rdata_d = cfg_q;
			end
			if (rd_flags) begin
				rdata_d = {2'h0, flags_q};
			end
		end
	end

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cfg_q <= `LFC_CFG_RESET;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flags_q <= 6'h00;
		end else begin
			flags_q <= flags_d;
		end
	end

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			chip_latched_off_o <= 1'b0;
		end else begin
			chip_latched_off_o <= latch_d;
		end
	end

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			string_off_o <= {CHANNELS{1'b0}};
		end else begin
			string_off_o <= string_off_d;
		end
	end

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flash_mode_enable_o <= 1'b0;
		end else begin
			flash_mode_enable_o <= flash_d;
		end
	end

	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reg_rdata_o <= 8'h00;
		end else begin
			reg_rdata_o <= rdata_d;
		end
	end

endmodule

// ==== lfc_regs.vh ====
// register offsets, field positions and reset values of the fault control block
`ifndef LFC_REGS_VH
`define LFC_REGS_VH
`define LFC_ADDR_CFG 8'h1E
`define LFC_ADDR_FLAGS 8'h1F
`define LFC_CFG_RESET 8'h43
`define LFC_TH_HI 7
`define LFC_TH_LO 6
`define LFC_SMD_HI 5
`define LFC_SMD_LO 4
`define LFC_OMD_HI 3
`define LFC_OMD_LO 2
`define LFC_OTP_DIS 1
`define LFC_OCP_DIS 0
`define LFC_F_UV 5
`define LFC_F_OPEN 4
`define LFC_F_SHORT 3
`define LFC_F_OT 2
`define LFC_F_OC 1
`define LFC_F_OV 0
`define LFC_SMD_OFF 2'h0
`define LFC_SMD_FLAG 2'h1
`define LFC_SMD_STR 2'h2
`define LFC_SMD_LATCH 2'h3
`define LFC_OMD_FLAG 2'h0
`define LFC_OMD_STR 2'h1
`define LFC_OMD_LATCH 2'h2
`define LFC_TH_RSV 2'h3
`endif

// ==== lfc_host.sv ====
// host model driving the register strobes
`timescale 1ns/100ps
module lfc_host (
	input wire core_clk_i,
	input wire [7:0] rdata_i,
	output reg wr_o = 1'b0,
	output reg rd_o = 1'b0,
	output reg [7:0] addr_o = 8'h00,
	output reg [7:0] wdata_o = 8'h00
);
	// entered just after a falling edge so the strobe spans one rising edge
	task wr(input [7:0] a, input [7:0] d);
	begin
		wr_o = 1'b1; addr_o = a; wdata_o = d;
		@(negedge core_clk_i);
		wr_o = 1'b0; wdata_o = ~d;
	end
	endtask
	task rd(input [7:0] a, output [7:0] d);
	begin
		rd_o = 1'b1; addr_o = a;
		@(negedge core_clk_i);
		rd_o = 1'b0;
		@(negedge core_clk_i);
		d = rdata_i;
	end
	endtask
endmodule

// ==== lfc_fault_ctrl_properties.sv ====
// port assertions for the fault control block
`timescale 1ns/100ps
module lfc_props (
	input wire core_clk_i,
	input wire reset_n_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire undervoltage_i,
	input wire overcurrent_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire [7:0] reg_rdata_o,
	input wire chip_latched_off_o,
	input wire [1:0] short_threshold_sel_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	wire rf = reg_rd_i && reg_addr_i == 8'h1F;
	wire wc = reg_wr_i && reg_addr_i == 8'h1E;
	AST_TH: assert property (wc |=> short_threshold_sel_o == $past(reg_wdata_i[7:6]))
		else $error("threshold not written");
	AST_THK: assert property (!wc |=> $stable(short_threshold_sel_o))
		else $error("threshold moved");
	AST_LAT: assert property (chip_latched_off_o |=> chip_latched_off_o)
		else $error("latch dropped");
	AST_RSV: assert property (rf |=> reg_rdata_o[7:6] == 2'h0)
		else $error("reserved bits set");
	AST_UV: assert property (undervoltage_i ##1 rf |=> reg_rdata_o[5])
		else $error("uv flag lost");
	AST_OC: assert property (overcurrent_i ##1 rf |=> reg_rdata_o[1])
		else $error("oc flag lost");
	AST_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved");
	AST_MAP: assert property (reg_rd_i && reg_addr_i[7:1] != 7'h0F |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind lfc_fault_ctrl lfc_props u_props (.*);

// ==== tb.sv ====
// self-checking bench for the fault control block
`timescale 1ns/100ps
module tb;
	reg clk = 1'b0, rst_n = 1'b0, few = 1'b0, fto = 1'b0;
	reg [5:0] flt = 6'h00;
	reg [2:0] sk = 3'h0;
	reg [2:0] s5 = 3'h0;
	reg [7:0] v;
	integer bad_count = 0, compares = 0, cyc = 0, i;
	wire w, r, fme, lat;
	wire [7:0] a, d, q;
	wire [2:0] so;
	wire [1:0] th;
	initial forever #2 clk = ~clk;
	lfc_host host (.core_clk_i(clk), .rdata_i(q), .wr_o(w), .rd_o(r), .addr_o(a), .wdata_o(d));
	lfc_fault_ctrl dut (.core_clk_i(clk), .reset_n_i(rst_n), .reg_wr_i(w), .reg_rd_i(r),
		.reg_addr_i(a), .reg_wdata_i(d), .reg_rdata_o(q), .sink_above_2v_i(sk | {3{flt[3]}}),
		.sink_above_3v_i({3{flt[3]}}), .sink_above_5v_i(s5), .string_open_i({3{flt[4]}}),
		.overvoltage_i(flt[0]), .undervoltage_i(flt[5]), .thermal_i(flt[2]),
		.overcurrent_i(flt[1]), .flash_timeout_i(fto), .flash_enable_wr_i(few),
		.flash_enable_wdata_i(1'b1), .flash_mode_enable_o(fme), .string_off_o(so),
		.chip_latched_off_o(lat), .short_threshold_sel_o(th));
	task chk(input [7:0] s, input [7:0] e);
	begin
		compares = compares + 1;
		if (s !== e) begin
			bad_count = bad_count + 1;
			$display("BAD t=%0t seen %h expected %h", $time, s, e);
		end
	end
	endtask
	task rc(input [7:0] ad, input [7:0] e);
	begin
		host.rd(ad, v);
		chk(v, e);
	end
	endtask
	task stop_test;
	begin
		$display("mismatches %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	end
	endtask
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			bad_count = bad_count + 1;
			stop_test;
		end
	end
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		rc(8'h1E, 8'h43);
		rc(8'h20, 8'h00);
		host.wr(8'h1E, 8'h53);
		for (i = 0; i < 6; i = i + 1) begin
			flt = 6'h01 << i;
			@(negedge clk);
			flt = 6'h00;
			rc(8'h1F, 8'h01 << i);
			rc(8'h1F, 8'h00);
		end
		// fault during the clearing read must survive
		flt = 6'h02;
		fork
			rc(8'h1F, 8'h00);
			@(negedge clk) flt = 6'h00;
		join
		rc(8'h1F, 8'h02);
		few = 1'b1;
		@(negedge clk) few = 1'b0;
		@(negedge clk) chk({7'h0, fme}, 8'h01);
		fto = 1'b1;
		@(negedge clk) fto = 1'b0;
		@(negedge clk) chk({7'h0, fme}, 8'h00);
		host.wr(8'h1E, 8'h21);
		sk = 3'h2;
		@(negedge clk) sk = 3'h0;
		@(negedge clk) chk({5'h0, so}, 8'h02);
		rc(8'h1F, 8'h08);
		flt = 6'h04;
		@(negedge clk) flt = 6'h00;
		@(negedge clk) chk({7'h0, lat}, 8'h01);
		rc(8'h1F, 8'h04);
		rc(8'h1F, 8'h04);
		// mid-run reset, then over-voltage string drop and over-current latch
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		chk({7'h0, lat}, 8'h00);
		chk({6'h0, th}, 8'h01);
		host.wr(8'h1E, 8'h46);
		flt = 6'h11;
		@(negedge clk) flt = 6'h00;
		@(negedge clk) chk({5'h0, so}, 8'h07);
		chk({7'h0, lat}, 8'h00);
		rc(8'h1F, 8'h11);
		flt = 6'h02;
		@(negedge clk) flt = 6'h00;
		@(negedge clk) chk({7'h0, lat}, 8'h01);
		// 5V threshold with latch-off short mode
		rst_n = 1'b0;
		@(negedge clk) rst_n = 1'b1;
		host.wr(8'h1E, 8'hB3);
		sk = 3'h1;
		@(negedge clk) sk = 3'h0;
		@(negedge clk) chk({7'h0, lat}, 8'h00);
		sk = 3'h1;
		s5 = 3'h1;
		@(negedge clk) s5 = 3'h0;
		sk = 3'h0;
		@(negedge clk) chk({7'h0, lat}, 8'h01);
		rc(8'h1F, 8'h08);
		stop_test;
	end
endmodule
